// *** core/pwm_prescaler.sv ***
// clock tick prescaler for the pwm counter
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler
	import pwm_pkg::*;
#(
	parameter int W = PRE_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// control
	input wire logic run_i,
	input wire logic src_tick_i,
	input wire logic [2:0] div_i,
	// tick out
	output logic tick_o
);
	logic [W-1:0] cnt;
	logic [W-1:0] mask;
	assign mask = W'((8'h01 << div_i) - 8'h01);
	// tick when the low div bits of the count are all ones
	assign tick_o = run_i & src_tick_i & ((cnt & mask) == mask);
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !run_i) begin
			cnt <= '0;
		end else if (src_tick_i) begin
			cnt <= cnt + W'(1);
		end
	end
endmodule // pwm_prescaler
`default_nettype wire

// *** core/triple_pwm_generator.sv ***
// triple 11-bit pwm generator with io-space registers
`timescale 1ns/1ps
`default_nettype none
module triple_pwm_generator
	import pwm_pkg::*;
#(
	parameter bit FAST_X2 = 1'b0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// io space access
	input wire io_req_s io_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// sources
	input wire logic fast_osc_i,
	input wire logic comp_i,
	// interrupt
	input wire logic irq_en_i,
	input wire logic irq_clr_i,
	output logic irq_req_o,
	output logic irq_o,
	// pins
	output pins_s pin_o,
	output pins_s pin_oe_n_o
);
	// registers
	logic [7:0] ctl [3];
	logic [7:0] clk_setup;
	logic [2:0] duty_lo_hold [3];
	logic [10:0] duty [3];
	logic [10:0] bound;
	logic [10:0] cnt;
	logic [2:0] gen;
	logic div2;
	logic irq_req;
	logic [2:0] osc_sync;
	logic [2:0] comp_sync;
	logic osc_q;
	logic comp_q;

	// address decode
	function automatic logic hit(input io_req_s r, input logic [5:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// port field decode shared by the three outputs
	function automatic logic route_on(input logic [2:0] code,
		input logic [2:0] want);
		return code == want;
	endfunction

	// control readback with the live generator level in bit 6
	function automatic logic [7:0] ctl_view(input logic [7:0] c,
		input logic lvl, input logic hide_inv);
		logic [7:0] v;
		v = c;
		v[CTL_STATUS] = lvl;
		// write-only invert must not leak back to software
		if (hide_inv) begin
			v[CTL_INV] = 1'b0;
		end
		return v;
	endfunction

	wire logic [5:0] ctl_ofs [3];
	wire logic [5:0] dth_ofs [3];
	wire logic [5:0] dtl_ofs [3];
	assign ctl_ofs[0] = OFS_OUT0_CTRL;
	assign ctl_ofs[1] = OFS_OUT1_CTRL;
	assign ctl_ofs[2] = OFS_OUT2_CTRL;
	assign dth_ofs[0] = OFS_OUT0_DTH;
	assign dth_ofs[1] = OFS_OUT1_DTH;
	assign dth_ofs[2] = OFS_OUT2_DTH;
	assign dtl_ofs[0] = OFS_OUT0_DTL;
	assign dtl_ofs[1] = OFS_OUT1_DTL;
	assign dtl_ofs[2] = OFS_OUT2_DTL;

	// write strobes, a named wire or a three-bit per-output vector per register
	genvar g;
	wire logic clk_we;
	wire logic bnd_h_we;
	wire logic bnd_l_we;
	wire logic [2:0] ctl_we;
	wire logic [2:0] dtl_we;
	wire logic [2:0] dth_we;
	assign clk_we = hit(io_i, OFS_CLK_SETUP);
	assign bnd_h_we = hit(io_i, OFS_BOUND_H);
	assign bnd_l_we = hit(io_i, OFS_BOUND_L);
	generate
		for (g = 0; g < 3; g++) begin : g_we
			assign ctl_we[g] = hit(io_i, ctl_ofs[g]);
			assign dtl_we[g] = hit(io_i, dtl_ofs[g]);
			assign dth_we[g] = hit(io_i, dth_ofs[g]);
		end
	endgenerate

	// pin synchronisers: change taken once stages 2 and 3 agree
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			osc_sync <= 3'h0;
			osc_q <= 1'b0;
		end else begin
			osc_sync <= {osc_sync[1:0], fast_osc_i};
			if (osc_sync[1] == osc_sync[2]) begin
				osc_q <= osc_sync[2];
			end
		end
	end

	// comparator level, same three-stage scheme
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			comp_sync <= 3'h0;
			comp_q <= 1'b0;
		end else begin
			comp_sync <= {comp_sync[1:0], comp_i};
			if (comp_sync[1] == comp_sync[2]) begin
				comp_q <= comp_sync[2];
			end
		end
	end

	// fast oscillator events: rising edges, or both edges for twice rate
	wire logic osc_agree;
	wire logic osc_rise;
	wire logic osc_any;
	wire logic src_tick;
	assign osc_agree = osc_sync[1] == osc_sync[2];
	assign osc_rise = osc_agree & osc_sync[2] & ~osc_q;
	assign osc_any = osc_agree & (osc_sync[2] ^ osc_q);
	// oscillator must run well below clk_i or edges are lost
	wire logic osc_sel;
	assign osc_sel = clk_setup[CLK_SRC];
	assign src_tick = osc_sel ?
		(FAST_X2 ? osc_any : osc_rise) : 1'b1;

	// enable and divider code straight from the setup register
	wire logic run;
	wire logic tick;
	wire logic [2:0] div_code;
	assign run = clk_setup[CLK_EN];
	assign div_code = clk_setup[CLK_PRE_LO +: 3];
	pwm_prescaler #(
		.W(PRE_W)
	) u_pre (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.run_i(run),
		.src_tick_i(src_tick),
		.div_i(div_code),
		.tick_o(tick)
	);

	// shared counter
	wire logic wrap;
	wire logic [10:0] next_cnt;
	// >= so a bound lowered under the count wraps at once
	assign wrap = tick & (cnt >= bound);
	assign next_cnt = !run ? 11'h000 : wrap ? 11'h000 :
		tick ? cnt + 11'h001 : cnt;

	// shared counter register
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt <= 11'h000;
		end else begin
			cnt <= next_cnt;
		end
	end

	// clock setup; reserved bits 3..1 store as zero
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			clk_setup <= CLK_RESET;
		end else if (clk_we) begin
			clk_setup <= io_i.wdata & 8'hF1;
		end
	end

	// bound bit 0 is not programmable and stays one
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bound <= BOUND_RESET;
		end else begin
			if (bnd_h_we) begin
				bound[10:3] <= io_i.wdata;
			end
			if (bnd_l_we) begin
				bound[2:1] <= io_i.wdata[7:6];
			end
			bound[0] <= 1'b1;
		end
	end

	// per-output registers and compare
	wire logic [2:0] below;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			assign below[g] = run & (next_cnt < duty[g]);
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					ctl[g] <= CTL_RESET;
				end else if (ctl_we[g]) begin
					// status bit 6 is never stored
					ctl[g] <= io_i.wdata & 8'hBF;
				end
			end

			// low part waits for its high write
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					duty_lo_hold[g] <= 3'h0;
				end else if (dtl_we[g]) begin
					duty_lo_hold[g] <= io_i.wdata[7:5];
				end
			end

			// whole value loads only on the high write
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					duty[g] <= DUTY_RESET;
				end else if (dth_we[g]) begin
					duty[g] <= {io_i.wdata, duty_lo_hold[g]};
				end
			end

			// registered level feeds pins and readback alike
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					gen[g] <= 1'b0;
				end else begin
					gen[g] <= below[g];
				end
			end
		end
	endgenerate

	// divide-by-two of output two, toggles each period start
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			div2 <= 1'b0;
		end else if (wrap) begin
			div2 <= ~div2;
		end
	end

	// request is sticky; set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irq_req <= 1'b0;
		end else if (wrap) begin
			irq_req <= 1'b1;
		end else if (irq_clr_i) begin
			irq_req <= 1'b0;
		end
	end
	assign irq_req_o = irq_req;
	assign irq_o = irq_req & irq_en_i;

	// output shaping
	wire logic [2:0] gated;
	wire logic [2:0] shaped;
	generate
		for (g = 0; g < 3; g++) begin : g_gate
			assign gated[g] = gen[g] & (~ctl[g][CTL_GATE] | comp_q);
		end
	endgenerate
	wire logic mix0;
	assign mix0 = ctl[0][CTL_MIX] ? (gated[0] | gated[1]) :
		(gated[0] ^ gated[1]);
	wire logic [2:0] src;
	assign src[0] = ctl[0][CTL_SEL] ? mix0 : gated[0];
	assign src[1] = ctl[1][CTL_SEL] ? gated[2] : gated[1];
	assign src[2] = ctl[2][CTL_SEL] ? (gated[2] & div2) : gated[2];
	generate
		for (g = 0; g < 3; g++) begin : g_pol
			assign shaped[g] = src[g] ^ ctl[g][CTL_INV];
		end
	endgenerate

	// port routing; reserved codes leave the pin undriven
	wire logic [2:0] port0;
	wire logic [2:0] port1;
	wire logic [2:0] port2;
	assign port0 = ctl[0][CTL_PORT_LO +: 3];
	assign port1 = ctl[1][CTL_PORT_LO +: 3];
	assign port2 = ctl[2][CTL_PORT_LO +: 3];
	pins_s next_pin;
	assign next_pin.pa0 = shaped[0];
	assign next_pin.pa4 = shaped[1];
	assign next_pin.pa3 = shaped[2];
	assign next_pin.pa5 = shaped[2];

	// a pin is driven only for its one documented port code
	wire logic [3:0] drive;
	assign drive[3] = route_on(port0, PORT_PIN_A);
	assign drive[2] = route_on(port2, PORT_PIN_A);
	assign drive[1] = route_on(port1, PORT_PIN_A);
	assign drive[0] = route_on(port2, PORT_PIN_B);
	assign pin_oe_n_o = ~drive;

	// pin levels leave from a flop so loads never see decode glitches
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pin_o <= '0;
		end else begin
			pin_o <= next_pin;
		end
	end

	// readback: control registers only, bit 6 live, bit 5 of ch0 write-only
	wire logic [7:0] ctl_rd [3];
	assign ctl_rd[0] = ctl_view(ctl[0], gen[0], 1'b1);
	assign ctl_rd[1] = ctl_view(ctl[1], gen[1], 1'b0);
	assign ctl_rd[2] = ctl_view(ctl[2], gen[2], 1'b0);
	logic [7:0] rd;
	always_comb begin
		rd = 8'h00;
		case (io_i.addr)
			OFS_OUT0_CTRL: rd = ctl_rd[0];
			OFS_OUT1_CTRL: rd = ctl_rd[1];
			OFS_OUT2_CTRL: rd = ctl_rd[2];
			default: rd = 8'h00;
		endcase
	end

	// answer strobe one cycle after the read
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= io_i.rd;
		end
	end

	// data is zero outside the answer cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= io_i.rd ? rd : 8'h00;
		end
	end
endmodule // triple_pwm_generator
`default_nettype wire

// *** dv/pwm_asserts.sv ***
// port checker for the triple pwm generator
`timescale 1ns/1ps
`default_nettype none
module pwm_asserts
	import pwm_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// io and status
	input wire io_req_s io_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic irq_en_i,
	input wire logic irq_req_o,
	input wire logic irq_o,
	input wire pins_s pin_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence rd_s(a);
		io_i.rd && io_i.addr == a;
	endsequence
	sequence wr_s(a, p);
		io_i.wr && io_i.addr == a && io_i.wdata[3:1] == p;
	endsequence
	rd_answer_a: assert property (io_i.rd |=> rvalid_o)
		else $error("read not answered");
	rd_idle_a: assert property (!rvalid_o |-> rdata_o == 8'h00)
		else $error("read data without answer");
	wo_read_a: assert property (rd_s(OFS_CLK_SETUP) |=> !rdata_o)
		else $error("clock setup reads back");
	inv_hidden_a: assert property (rd_s(OFS_OUT0_CTRL) |=> !rdata_o[5])
		else $error("invert bit reads back");
	irq_gate_a: assert property (irq_o == (irq_req_o & irq_en_i))
		else $error("interrupt not gated by enable");
	pin0_on_a: assert property (
		wr_s(OFS_OUT0_CTRL, PORT_PIN_A) |=> !pin_oe_n_o.pa0)
		else $error("pin 0 not driven");
	pin4_off_a: assert property (
		wr_s(OFS_OUT1_CTRL, PORT_OFF) |=> pin_oe_n_o.pa4)
		else $error("pin 4 still driven");
	pin5_on_a: assert property (
		wr_s(OFS_OUT2_CTRL, PORT_PIN_B) |=> !pin_oe_n_o.pa5 && pin_oe_n_o.pa3)
		else $error("output two routed wrongly");
endmodule // pwm_asserts
bind triple_pwm_generator pwm_asserts chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
	.io_i(io_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .irq_en_i(irq_en_i),
	.irq_req_o(irq_req_o), .irq_o(irq_o), .pin_oe_n_o(pin_oe_n_o));
`default_nettype wire

// *** dv/pwm_load.sv ***
// led loads hanging on the port a pins
`timescale 1ns/1ps
`default_nettype none
module pwm_load
	import pwm_pkg::*;
(
	// pin drive
	input wire pins_s pin_i,
	input wire pins_s oe_n_i,
	// level at each load
	output pins_s pad_o
);
	// an undriven pin sinks through its led to ground
	assign pad_o = pin_i & ~oe_n_i;
endmodule // pwm_load
`default_nettype wire

// *** dv/triple_pwm_generator_bench.sv ***
// self-checking bench for the triple pwm generator
`timescale 1ns/1ps
`default_nettype none
module triple_pwm_generator_bench;
	import pwm_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	io_req_s io_i = '0;
	logic irq_en_i = 1'b0;
	logic irq_clr_i = 1'b0;
	logic [7:0] rdata_o, got;
	logic rvalid_o, irq_req_o, irq_o;
	pins_s pin_o, pin_oe_n_o, pad;
	int miscompares = 0;
	int n_checks = 0;
	int run;
	int pin_sel = 3;
	logic comp = 1'b0;
	logic osc = 1'b0;
	logic osc_on = 1'b0;
	// address, write data, read back
	logic [23:0] rows [8] = '{24'h20A787, 24'h26B6B6, 24'h2CBABA,
		24'h210000, 24'h220000, 24'h250000, 24'h27AA00, 24'h3F5500};
	triple_pwm_generator dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .io_i(io_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .fast_osc_i(osc),
		.comp_i(comp), .irq_en_i(irq_en_i), .irq_clr_i(irq_clr_i),
		.irq_req_o(irq_req_o), .irq_o(irq_o), .pin_o(pin_o),
		.pin_oe_n_o(pin_oe_n_o));
	pwm_load load_u (.pin_i(pin_o), .oe_n_i(pin_oe_n_o), .pad_o(pad));
	always #5 clk_i = ~clk_i;
	// slow stand-in for the fast oscillator: an edge every four cycles
	always begin
		repeat (4) @(posedge clk_i);
		#1 osc = osc_on & ~osc;
	end
	task automatic tick;
		@(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		io_i = '{1'b1, 1'b0, a, d};
		tick();
		io_i = '0;
		tick();
	endtask
	task automatic rd(input logic [5:0] a);
		io_i = '{1'b0, 1'b1, a, 8'h00};
		tick();
		got = rdata_o;
		io_i = '0;
		tick();
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	// longest high stretch on the chosen pin over n cycles
	task automatic hi_run(input int n);
		int cur;
		cur = 0;
		run = 0;
		repeat (n) begin
			tick();
			cur = pad[pin_sel] ? cur + 1 : 0;
			if (cur > run) run = cur;
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// whole run is under a thousand cycles, the time limit twenty thousand
	initial begin
		#200000;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		cmp({rvalid_o, irq_req_o, 2'b00, pin_oe_n_o}, 8'h0F);
		tick();
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i][21:16], rows[i][15:8]);
			rd(rows[i][21:16]);
			cmp(got, rows[i][7:0]);
		end
		$display("register test done");
		wr(OFS_OUT1_CTRL, 8'h00);
		wr(OFS_BOUND_H, 8'h00);
		wr(OFS_BOUND_L, 8'h40);
		wr(OFS_OUT0_DTL, 8'h20);
		wr(OFS_OUT0_DTH, 8'h00);
		wr(OFS_OUT0_CTRL, 8'h06);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CLK_SETUP, {1'b1, 3'(k), 4'h0});
			hi_run(80);
			cmp(8'(run), 8'(1 << k));
		end
		wr(OFS_CLK_SETUP, 8'h80);
		wr(OFS_OUT0_CTRL, 8'h26);
		hi_run(40);
		cmp(8'(run), 8'h03);
		wr(OFS_OUT0_CTRL, 8'h06);
		wr(OFS_OUT0_DTL, 8'h40);
		hi_run(40);
		cmp(8'(run), 8'h01);
		wr(OFS_OUT0_DTH, 8'h00);
		hi_run(40);
		cmp(8'(run), 8'h02);
		wr(OFS_OUT1_DTL, 8'h60);
		wr(OFS_OUT1_DTH, 8'h00);
		wr(OFS_OUT0_CTRL, 8'h17);
		hi_run(40);
		cmp(8'(run), 8'h03);
		$display("waveform test done");
		cmp({7'h00, irq_req_o}, 8'h01);
		wr(OFS_CLK_SETUP, 8'h00);
		irq_clr_i = 1'b1;
		tick();
		irq_clr_i = 1'b0;
		tick();
		cmp({7'h00, irq_req_o}, 8'h00);
		wr(OFS_CLK_SETUP, 8'h80);
		run = 0;
		while (irq_req_o !== 1'b1 && run < 8) begin
			tick();
			run++;
		end
		cmp({6'h00, irq_req_o, irq_o}, 8'h02);
		irq_en_i = 1'b1;
		#1;
		cmp({7'h00, irq_o}, 8'h01);
		$display("interrupt test done");
		wr(OFS_OUT0_CTRL, 8'h86);
		hi_run(40);
		cmp(8'(run), 8'h00);
		comp = 1'b1;
		hi_run(40);
		cmp(8'(run), 8'h02);
		wr(OFS_OUT2_DTH, 8'hFF);
		rd(OFS_OUT2_CTRL);
		cmp(got, 8'hFA);
		wr(OFS_OUT2_CTRL, 8'h9A);
		pin_sel = 0;
		hi_run(40);
		cmp(8'(run), 8'h04);
		wr(OFS_OUT2_CTRL, 8'h86);
		pin_sel = 2;
		hi_run(40);
		cmp(8'(run), 8'h28);
		wr(OFS_OUT1_CTRL, 8'h16);
		pin_sel = 1;
		hi_run(40);
		cmp(8'(run), 8'h28);
		wr(OFS_OUT1_CTRL, 8'h36);
		hi_run(40);
		cmp(8'(run), 8'h00);
		$display("routing test done");
		osc_on = 1'b1;
		wr(OFS_CLK_SETUP, 8'h81);
		pin_sel = 3;
		hi_run(80);
		cmp(8'(run), 8'h10);
		$display("oscillator test done");
		nrst_i = 1'b0;
		repeat (2) tick();
		nrst_i = 1'b1;
		cmp({rvalid_o, irq_req_o, 2'b00, pin_oe_n_o}, 8'h0F);
		cmp({4'h0, pin_o}, 8'h00);
		$display("second reset test done");
		stop_test();
	end
endmodule // triple_pwm_generator_bench
`default_nettype wire

// *** inc/pwm_pkg.sv ***
// constants and types for the triple pwm generator
// Functional notes
// - a global enable runs or stops the generator and a 3-bit prescaler divides its clock by 1 to 128.
// - a source select bit picks the system clock or the fast oscillator (or twice it by build option).
// - each duty value is 11 bits, high register bits 10..3, low register bits 7..5 hold bits 2..0.
// - the shared bound is high bits 10..3 and low bits 7..6 as bits 2..1, with bit 0 fixed.
// - control bit 7 lets the comparator result gate that output.
// - control bit 6 reads back the present level of that output's generator.
// - output zero bit 4 selects own waveform or a combination with output one, xor or or by bit 0.
// - output zero bit 5 is a write-only polarity invert.
// - output zero port field 000 disconnects and 011 drives port a pin 0.
// - output one bit 5 inverts and bit 4 selects output one's or output two's waveform.
// - output one port field 000 disconnects and 011 drives port a pin 4.
// - output two bit 5 inverts and bit 4 selects the waveform or the waveform divided by two.
// - output two port field 000 disconnects, 011 drives port a pin 3 and 101 drives pin 5.
// - the generator raises an interrupt request bit set by hardware and cleared by software, gated by an enable.
package pwm_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_OUT0_CTRL = 6'h20;
	localparam logic [5:0] OFS_CLK_SETUP = 6'h21;
	localparam logic [5:0] OFS_OUT0_DTH = 6'h22;
	localparam logic [5:0] OFS_OUT0_DTL = 6'h23;
	localparam logic [5:0] OFS_BOUND_H = 6'h24;
	localparam logic [5:0] OFS_BOUND_L = 6'h25;
	localparam logic [5:0] OFS_OUT1_CTRL = 6'h26;
	localparam logic [5:0] OFS_OUT1_DTH = 6'h28;
	localparam logic [5:0] OFS_OUT1_DTL = 6'h29;
	localparam logic [5:0] OFS_OUT2_CTRL = 6'h2C;
	localparam logic [5:0] OFS_OUT2_DTH = 6'h2E;
	localparam logic [5:0] OFS_OUT2_DTL = 6'h2F;
	// control fields
	localparam int CTL_GATE = 7;
	localparam int CTL_STATUS = 6;
	localparam int CTL_INV = 5;
	localparam int CTL_SEL = 4;
	localparam int CTL_PORT_LO = 1;
	localparam int CTL_MIX = 0;
	// clock setup fields
	localparam int CLK_EN = 7;
	localparam int CLK_PRE_LO = 4;
	localparam int CLK_SRC = 0;
	localparam logic [2:0] PORT_OFF = 3'h0;
	localparam logic [2:0] PORT_PIN_A = 3'h3;
	localparam logic [2:0] PORT_PIN_B = 3'h5;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CLK_RESET = 8'h00;
	localparam logic [10:0] DUTY_RESET = 11'h000;
	localparam logic [10:0] BOUND_RESET = 11'h7FF;
	localparam int PRE_W = 7;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} io_req_s;

	typedef struct packed {
		logic pa0;
		logic pa3;
		logic pa4;
		logic pa5;
	} pins_s;
endpackage
